// ### verilog/rotu_pkg.sv
// Constants and types shared by the rotate datapath.
`default_nettype none
package rotu_pkg;
   // Register map, byte addresses of aligned 32-bit words.
   localparam logic [7:0] OFF_AF = 8'h00;
   localparam logic [7:0] OFF_BC = 8'h04;
   localparam logic [7:0] OFF_DE = 8'h08;
   localparam logic [7:0] OFF_PTR = 8'h0C;
   localparam logic [7:0] OFF_IDX = 8'h10;
   localparam logic [7:0] OFF_INSN = 8'h14;
   localparam logic [7:0] OFF_STAT = 8'h18;
   // Values after reset.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [31:0] RST_INSN = 32'h00000000;
   // Opcode bytes.
   localparam logic [7:0] OP_ACC_LC = 8'h07;
   localparam logic [7:0] OP_ACC_LV = 8'h17;
   localparam logic [7:0] OP_ACC_RC = 8'h0F;
   localparam logic [7:0] OP_ACC_RV = 8'h1F;
   localparam logic [7:0] BIT_OP_PREFIX_BYTE = 8'hCB;
   localparam logic [7:0] INDEX_X_PREFIX_BYTE = 8'hDD;
   localparam logic [7:0] OP_MEM_LC = 8'h06;
   localparam logic [4:0] PFX_ROT_FIELD = 5'h00;
   // Register field codes.
   localparam logic [2:0] RF_B = 3'h0;
   localparam logic [2:0] RF_C = 3'h1;
   localparam logic [2:0] RF_D = 3'h2;
   localparam logic [2:0] RF_E = 3'h3;
   localparam logic [2:0] RF_H = 3'h4;
   localparam logic [2:0] RF_L = 3'h5;
   localparam logic [2:0] RF_MEM = 3'h6;
   localparam logic [2:0] RF_A = 3'h7;
   // Clock states per instruction and memory access points.
   localparam logic [4:0] T_ACC = 5'h04;
   localparam logic [4:0] T_REG = 5'h08;
   localparam logic [4:0] T_PTR = 5'h0F;
   localparam logic [4:0] T_IDX = 5'h17;
   localparam logic [4:0] T_PTR_RD = 5'h08;
   localparam logic [4:0] T_PTR_WR = 5'h0C;
   localparam logic [4:0] T_IDX_RD = 5'h10;
   localparam logic [4:0] T_IDX_WR = 5'h14;
   // Flag bit positions.
   localparam int FL_S = 7;
   localparam int FL_Z = 6;
   localparam int FL_H = 4;
   localparam int FL_PV = 2;
   localparam int FL_N = 1;
   localparam int FL_C = 0;
   // Status bit positions.
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_ERR = 2;
   localparam int ST_CYC_LSB = 8;

   typedef enum logic [0:0] {
      RU_IDLE = 1'b0,
      RU_RUN = 1'b1
   } rotu_state_t;

   typedef enum logic [2:0] {
      K_ACC_LC = 3'b000,
      K_ACC_LV = 3'b001,
      K_ACC_RC = 3'b010,
      K_ACC_RV = 3'b011,
      K_REG = 3'b100,
      K_PTR = 3'b101,
      K_IDX = 3'b110
   } rotu_kind_t;
endpackage
`default_nettype wire

// ### verilog/rotu_top.sv
// Rotate datapath with its register file, APB slave and memory port.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Contract
// RULE1: Opcode 07 rotates accumulator left circularly, 4 states.
// RULE2: Opcode 17 rotates accumulator left through carry.
// RULE3: Opcode 0F rotates accumulator right circularly, 4 states.
// RULE4: Opcode 1F rotates accumulator right through carry.
// RULE5: Left accumulator rotates: carry old bit 7.
// RULE6: Right accumulator rotates: carry old bit 0.
// RULE7: Prefix then 00000rrr rotates register left, 8 states.
// RULE8: Field codes select B,C,D,E,H,L,A; 110 not register.
// RULE9: Prefixed rotate: sign and zero from result.
// RULE10: Prefixed rotate: parity even flag; half, subtract cleared.
// RULE11: Prefixed rotate carry equals operand bit 7.
// RULE12: Prefix then 06 rotates pointer-pair memory, 15 states.
// RULE13: Index prefix form rotates index plus displacement memory.
// RULE14: Memory forms read, rotate, write back same address.
module rotu_top
   import rotu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack,
   output logic busy
);

   typedef struct packed {
      rotu_state_t st;
      rotu_kind_t kind;
      logic [2:0] rsel;
      logic [7:0] a;
      logic [7:0] f;
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] d;
      logic [7:0] e;
      logic [7:0] h;
      logic [7:0] l;
      logic [15:0] xreg;
      logic [31:0] insn;
      logic [4:0] tcnt;
      logic [7:0] cyc;
      logic [7:0] last_cyc;
      logic [7:0] opnd;
      logic [15:0] maddr;
      logic mrd;
      logic mwr;
      logic done;
      logic err;
      logic [31:0] rdata;
   } rotu_s_t;

   rotu_s_t s_reg;
   rotu_s_t s_next;

   function automatic logic [7:0] rot_left(input logic [7:0] v,
                                           input logic in0);
      rot_left = {v[6:0], in0};
   endfunction

   function automatic logic [7:0] rot_right(input logic [7:0] v,
                                            input logic in7);
      rot_right = {in7, v[7:1]};
   endfunction

   function automatic logic [4:0] t_total(input rotu_kind_t k);
      case (k)
         K_REG: t_total = T_REG;
         K_PTR: t_total = T_PTR;
         K_IDX: t_total = T_IDX;
         default: t_total = T_ACC;
      endcase
   endfunction

   // Flags of the prefixed rotate from operand and result.
   function automatic logic [7:0] pfx_flags(input logic [7:0] op,
                                            input logic [7:0] r);
      logic [7:0] fl;
      fl = 8'h00;
      fl[FL_S] = r[7]; // RULE9
      fl[FL_Z] = (r == 8'h00); // RULE9
      fl[FL_PV] = ~^r; // RULE10
      fl[FL_C] = op[7]; // RULE11
      pfx_flags = fl;
   endfunction

   // Flags of the accumulator rotates; half-carry and subtract drop.
   function automatic logic [7:0] acc_flags(input logic [7:0] fo,
                                            input logic cy);
      logic [7:0] fl;
      fl = fo;
      fl[FL_H] = 1'b0;
      fl[FL_N] = 1'b0;
      fl[FL_C] = cy;
      acc_flags = fl;
   endfunction

   function automatic logic [7:0] reg_pick(input rotu_s_t s,
                                           input logic [2:0] code);
      case (code) // RULE8
         RF_B: reg_pick = s.b;
         RF_C: reg_pick = s.c;
         RF_D: reg_pick = s.d;
         RF_E: reg_pick = s.e;
         RF_H: reg_pick = s.h;
         RF_L: reg_pick = s.l;
         RF_A: reg_pick = s.a;
         default: reg_pick = 8'h00;
      endcase
   endfunction

   // Status word; its count covers clock states but not memory waits.
   function automatic logic [31:0] stat_word(input rotu_s_t s);
      logic [31:0] w;
      w = 32'h00000000;
      w[ST_BUSY] = (s.st == RU_RUN);
      w[ST_DONE] = s.done;
      w[ST_ERR] = s.err;
      w[ST_CYC_LSB +: 8] = s.last_cyc;
      stat_word = w;
   endfunction

   logic setup;
   logic access;
   logic known;
   logic refuse;
   logic stall;
   logic [7:0] b0;
   logic [7:0] b1;
   logic [7:0] b2;
   logic [7:0] b3;
   logic [7:0] rv;
   logic [7:0] rr;
   logic [4:0] tn;

   assign setup = psel & ~penable & ce;
   assign access = psel & penable & ce;
   assign known = (paddr == OFF_AF) | (paddr == OFF_BC) |
                  (paddr == OFF_DE) | (paddr == OFF_PTR) |
                  (paddr == OFF_IDX) | (paddr == OFF_INSN) |
                  (paddr == OFF_STAT);
   // Register writes during a run would corrupt the operand, so refuse.
   assign refuse = ~known | (pwrite & (s_reg.st == RU_RUN)) |
                   (pwrite & (paddr == OFF_STAT));
   // A frozen clock enable must not let an access complete.
   assign pready = psel & penable & ce;
   assign pslverr = pready & refuse;
   // The memory answer is same-clock logic, so it is read unsynchronised.
   // A memory wait holds the run counter until the answer comes.
   assign stall = (s_reg.mrd | s_reg.mwr) & ~mem_ack;

   always_comb begin
      s_next = s_reg;
      b0 = pwdata[7:0];
      b1 = pwdata[15:8];
      b2 = pwdata[23:16];
      b3 = pwdata[31:24];
      rv = 8'h00;
      rr = 8'h00;
      tn = 5'h00;
      // Read data is captured in the setup phase so it stands for the access.
      if (setup) begin
         case (paddr)
            OFF_AF: s_next.rdata = {16'h0000, s_reg.a, s_reg.f};
            OFF_BC: s_next.rdata = {16'h0000, s_reg.b, s_reg.c};
            OFF_DE: s_next.rdata = {16'h0000, s_reg.d, s_reg.e};
            OFF_PTR: s_next.rdata = {16'h0000, s_reg.h, s_reg.l};
            OFF_IDX: s_next.rdata = {16'h0000, s_reg.xreg};
            OFF_INSN: s_next.rdata = s_reg.insn;
            OFF_STAT: s_next.rdata = stat_word(s_reg);
            default: s_next.rdata = 32'h00000000;
         endcase
      end
      if (access & pwrite & ~refuse) begin
         case (paddr)
            OFF_AF: {s_next.a, s_next.f} = pwdata[15:0];
            OFF_BC: {s_next.b, s_next.c} = pwdata[15:0];
            OFF_DE: {s_next.d, s_next.e} = pwdata[15:0];
            OFF_PTR: {s_next.h, s_next.l} = pwdata[15:0];
            OFF_IDX: s_next.xreg = pwdata[15:0];
            OFF_INSN: begin
               s_next.insn = pwdata;
               s_next.done = 1'b0;
               s_next.err = 1'b0;
               s_next.tcnt = 5'h00;
               s_next.cyc = 8'h00;
               // A stale operand of an earlier run must not reach the write.
               s_next.opnd = RST_BYTE;
               s_next.st = RU_RUN;
               if (b0 == OP_ACC_LC) begin
                  s_next.kind = K_ACC_LC;
               end else if (b0 == OP_ACC_LV) begin
                  s_next.kind = K_ACC_LV;
               end else if (b0 == OP_ACC_RC) begin
                  s_next.kind = K_ACC_RC;
               end else if (b0 == OP_ACC_RV) begin
                  s_next.kind = K_ACC_RV;
               end else if (b0 == BIT_OP_PREFIX_BYTE &&
                            b1[7:3] == PFX_ROT_FIELD) begin
                  s_next.rsel = b1[2:0];
                  if (b1[2:0] == RF_MEM) begin
                     s_next.kind = K_PTR; // RULE12
                     s_next.maddr = {s_reg.h, s_reg.l};
                  end else begin
                     s_next.kind = K_REG; // RULE7
                  end
               end else if (b0 == INDEX_X_PREFIX_BYTE &&
                            b1 == BIT_OP_PREFIX_BYTE &&
                            b3 == OP_MEM_LC) begin
                  s_next.kind = K_IDX; // RULE13
                  s_next.maddr = s_reg.xreg + {{8{b2[7]}}, b2};
               end else begin
                  s_next.err = 1'b1;
                  s_next.st = RU_IDLE;
               end
            end
            default: s_next.err = s_next.err;
         endcase
      end
      if (ce && s_reg.st == RU_RUN && !stall) begin
         s_next.cyc = s_reg.cyc + 8'h01;
         if (s_reg.mrd) begin
            s_next.opnd = mem_rdata; // RULE14
            s_next.mrd = 1'b0;
         end
         if (s_reg.mwr) begin
            s_next.mwr = 1'b0;
         end
         if (s_reg.tcnt == t_total(s_reg.kind) - 5'h01) begin
            s_next.st = RU_IDLE;
            s_next.done = 1'b1;
            s_next.last_cyc = s_reg.cyc + 8'h01;
            case (s_reg.kind)
               K_ACC_LC: begin
                  s_next.a = rot_left(s_reg.a, s_reg.a[7]); // RULE1
                  s_next.f = acc_flags(s_reg.f, s_reg.a[7]); // RULE5
               end
               K_ACC_LV: begin
                  s_next.a = rot_left(s_reg.a, s_reg.f[FL_C]); // RULE2
                  s_next.f = acc_flags(s_reg.f, s_reg.a[7]); // RULE5
               end
               K_ACC_RC: begin
                  s_next.a = rot_right(s_reg.a, s_reg.a[0]); // RULE3
                  s_next.f = acc_flags(s_reg.f, s_reg.a[0]); // RULE6
               end
               K_ACC_RV: begin
                  s_next.a = rot_right(s_reg.a, s_reg.f[FL_C]); // RULE4
                  s_next.f = acc_flags(s_reg.f, s_reg.a[0]); // RULE6
               end
               K_REG: begin
                  rv = reg_pick(s_reg, s_reg.rsel);
                  rr = rot_left(rv, rv[7]); // RULE7
                  s_next.f = pfx_flags(rv, rr); // RULE10
                  case (s_reg.rsel) // RULE8
                     RF_B: s_next.b = rr;
                     RF_C: s_next.c = rr;
                     RF_D: s_next.d = rr;
                     RF_E: s_next.e = rr;
                     RF_H: s_next.h = rr;
                     RF_L: s_next.l = rr;
                     default: s_next.a = rr;
                  endcase
               end
               K_PTR, K_IDX: begin
                  // Memory forms change only the flags among the registers.
                  s_next.f = pfx_flags(s_reg.opnd,
                     rot_left(s_reg.opnd, s_reg.opnd[7])); // RULE11
               end
               default: s_next.f = s_reg.f;
            endcase
         end else begin
            tn = s_reg.tcnt + 5'h01;
            s_next.tcnt = tn;
            // Strobes rise so that the access fills its own state.
            if (s_reg.kind == K_PTR) begin
               s_next.mrd = (tn == T_PTR_RD); // RULE12
               s_next.mwr = (tn == T_PTR_WR); // RULE14
            end
            if (s_reg.kind == K_IDX) begin
               s_next.mrd = (tn == T_IDX_RD); // RULE13
               s_next.mwr = (tn == T_IDX_WR); // RULE14
            end
         end
      end
   end

   // Clock enable low freezes the whole state, the run counter included.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '{
            st: RU_IDLE,
            kind: K_ACC_LC,
            rsel: RF_B,
            a: RST_BYTE,
            f: RST_BYTE,
            b: RST_BYTE,
            c: RST_BYTE,
            d: RST_BYTE,
            e: RST_BYTE,
            h: RST_BYTE,
            l: RST_BYTE,
            xreg: RST_WORD,
            insn: RST_INSN,
            tcnt: 5'h00,
            cyc: 8'h00,
            last_cyc: 8'h00,
            opnd: RST_BYTE,
            maddr: RST_WORD,
            mrd: 1'b0,
            mwr: 1'b0,
            done: 1'b0,
            err: 1'b0,
            rdata: 32'h00000000
         };
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.rdata;
   assign mem_addr = s_reg.maddr;
   assign mem_rd = s_reg.mrd;
   assign mem_wr = s_reg.mwr;
   // The written byte is the rotate of the byte just read.
   assign mem_wdata = rot_left(s_reg.opnd, s_reg.opnd[7]);
   assign busy = (s_reg.st == RU_RUN);

endmodule
`default_nettype wire

// ### tb/rotu_sva.sv
// Port assertions for the rotate datapath.
`timescale 1ns/1ns
`default_nettype none
module rotu_sva
   import rotu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack,
   input wire logic busy
);
   logic [4:0] cnt_reg;
   logic [4:0] exp_reg;
   logic [7:0] rd_reg;
   logic [15:0] ra_reg;
   wire logic go = pready && pwrite && paddr == OFF_INSN && !pslverr;
   // Memory wait cycles do not count as clock states.
   wire logic stall = (mem_rd || mem_wr) && !mem_ack;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 5'h00;
         exp_reg <= 5'h00;
         rd_reg <= 8'h00;
         ra_reg <= 16'h0000;
      end else begin
         if (go) begin
            cnt_reg <= 5'h00;
            exp_reg <= pwdata[7:0] == INDEX_X_PREFIX_BYTE ? T_IDX :
               pwdata[7:0] != BIT_OP_PREFIX_BYTE ? T_ACC :
               pwdata[15:8] == OP_MEM_LC ? T_PTR : T_REG;
         end else if (busy && ce && !stall) begin
            cnt_reg <= cnt_reg + 5'h01;
         end
         if (mem_rd && mem_ack) begin
            rd_reg <= mem_rdata;
            ra_reg <= mem_addr;
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   run_len_a:
      assert property ($fell(busy) |-> cnt_reg == exp_reg)
      else $error("instruction length wrong");
   run_start_a:
      assert property ($rose(busy) |-> $past(go))
      else $error("busy rose alone");
   rd_hold_a:
      assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
      else $error("read strobe dropped");
   wr_hold_a:
      assert property (mem_wr && !mem_ack |=> mem_wr && $stable(mem_wdata))
      else $error("write strobe dropped");
   wb_data_a:
      assert property (mem_wr |-> mem_wdata == {rd_reg[6:0], rd_reg[7]})
      else $error("written byte not rotated");
   wb_addr_a:
      assert property (mem_wr |-> mem_addr == ra_reg)
      else $error("write address");
   rd_once_a:
      assert property (mem_rd && mem_ack |=> !mem_rd) else $error("read twice");
   mem_idle_a:
      assert property (!busy |-> !mem_rd && !mem_wr) else $error("idle access");
   busy_wr_a:
      assert property (pready && pwrite && busy |-> pslverr)
      else $error("write taken while busy");
   cover property ($fell(busy) && exp_reg == T_IDX);
   cover property ($fell(busy) && exp_reg == T_PTR);
   cover property (mem_wr && !mem_ack);
endmodule
`default_nettype wire

// ### tb/rotu_top_bench.sv
// Self-checking bench for the rotate datapath.
`timescale 1ns/1ns
`default_nettype none
module rotu_top_bench
   import rotu_pkg::*;
();
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, mem_rd, mem_wr, busy, e;
   logic [15:0] mem_addr, wa;
   logic [7:0] mem_wdata, wd;
   logic [7:0] mem_rdata = 8'h00;
   logic mem_ack = 1'b0;
   logic fast = 1'b1;
   logic [31:0] q;
   int n_mismatch = 0;
   int checks = 0;
   rotu_top rotu_top_inst (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_addr, .mem_rd,
      .mem_wr, .mem_wdata, .mem_rdata, .mem_ack, .busy);
   initial begin
      forever #25 pclk = ~pclk;
   end
   // Slow mode answers each strobe one cycle late.
   always @(posedge pclk) begin
      mem_ack <= fast | ((mem_rd | mem_wr) & ~mem_ack);
      if (mem_wr && mem_ack) begin
         wa <= mem_addr;
         wd <= mem_wdata;
      end
   end
   task automatic chk(input string w, input logic [31:0] s, x);
      checks++;
      if (s !== x) begin
         n_mismatch++;
         $display("[ERR] %s exp %h seen %h", w, x, s);
      end
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic hang();
      n_mismatch++;
      report_and_stop();
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) hang();
   endtask
   task automatic wait_idle();
      int n;
      for (n = 0; n < 99; n++) begin
         @(posedge pclk);
         if (busy === 1'b0) break;
      end
      if (n == 99) hang();
   endtask
   task automatic run(input logic [31:0] insn);
      apb(1'b1, OFF_INSN, insn);
      wait_idle();
   endtask
   task automatic t_reset();
      apb(1'b0, OFF_AF, 32'h0);
      chk("af", q, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {31'h0, e}, 32'h1);
      apb(1'b1, OFF_STAT, 32'h7);
      chk("stat_wr", {31'h0, e}, 32'h1);
   endtask
   task automatic t_acc();
      logic [7:0] ops [4] = '{OP_ACC_LC, OP_ACC_LV, OP_ACC_RC, OP_ACC_RV};
      logic [7:0] a, f, r;
      logic c;
      for (int i = 0; i < 8; i++) begin
         a = i < 4 ? 8'h81 : 8'h42;
         f = i < 4 ? 8'h00 : 8'hFF;
         case (i % 4)
            0: r = {a[6:0], a[7]};
            1: r = {a[6:0], f[0]};
            2: r = {a[0], a[7:1]};
            default: r = {f[0], a[7:1]};
         endcase
         c = i % 4 < 2 ? a[7] : a[0];
         apb(1'b1, OFF_AF, {16'h0, a, f});
         run({24'h0, ops[i % 4]});
         apb(1'b0, OFF_AF, 32'h0);
         chk("acc_a", q[31:8], {16'h0, r});
         chk("acc_f", q[7:0], f & 8'hEC | {7'h0, c});
         apb(1'b0, OFF_STAT, 32'h0);
         chk("acc_cyc", q, {19'h0, T_ACC, 8'h02});
      end
   endtask
   task automatic t_freeze();
      apb(1'b1, OFF_AF, 32'h00008100);
      apb(1'b1, OFF_INSN, {24'h0, OP_ACC_LC});
      ce <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("frozen", {31'h0, busy}, 32'h1);
      ce <= 1'b1;
      wait_idle();
      apb(1'b0, OFF_AF, 32'h0);
      chk("frz_acc", q, {16'h0, 8'h03, 8'h01});
      apb(1'b0, OFF_STAT, 32'h0);
      chk("frz_cyc", q, {19'h0, T_ACC, 8'h02});
   endtask
   task automatic t_reg();
      logic [7:0] vals [8] = '{8'h80, 8'h00, 8'h7F, 8'h01, 8'hFF, 8'h55,
         8'h00, 8'hC3};
      logic [7:0] v, r, off, fx;
      logic [15:0] xp;
      for (int i = 0; i < 8; i++) begin
         if (i == 6) continue;
         v = vals[i];
         r = {v[6:0], v[7]};
         fx = {r[7], r == 8'h00, 3'b000, ~^r, 1'b0, v[7]};
         off = i == 7 ? OFF_AF : i < 2 ? OFF_BC : i < 4 ? OFF_DE : OFF_PTR;
         apb(1'b1, OFF_AF, {16'h0, i == 7 ? v : 8'h3C, 8'hFF});
         if (i != 7) apb(1'b1, off, {16'h0, v, v});
         run({16'h0, PFX_ROT_FIELD, i[2:0], BIT_OP_PREFIX_BYTE});
         apb(1'b0, off, 32'h0);
         xp = i == 7 ? {r, fx} : i % 2 ? {v, r} : {r, v};
         chk("pair", q, {16'h0, xp});
         apb(1'b0, OFF_AF, 32'h0);
         chk("flags", q[7:0], fx);
      end
      run({16'h0, 8'h08, BIT_OP_PREFIX_BYTE});
      apb(1'b0, OFF_STAT, 32'h0);
      chk("illegal", q & 32'h5, 32'h4);
   endtask
   task automatic mem_op(input logic [31:0] insn, input logic [7:0] d,
      input logic [15:0] a, input logic [4:0] cyc);
      logic [7:0] r, fx;
      r = {d[6:0], d[7]};
      fx = {r[7], r == 8'h00, 3'b000, ~^r, 1'b0, d[7]};
      mem_rdata <= d;
      apb(1'b1, OFF_AF, 32'h00005AFF);
      run(insn);
      chk("waddr", wa, a);
      chk("wdata", wd, r);
      apb(1'b0, OFF_AF, 32'h0);
      chk("mflags", q, {16'h005A, fx});
      apb(1'b0, OFF_STAT, 32'h0);
      if (fast) chk("mcyc", q, {19'h0, cyc, 8'h02});
   endtask
   task automatic t_ptr();
      apb(1'b1, OFF_PTR, 32'h00002828);
      mem_op({16'h0, OP_MEM_LC, BIT_OP_PREFIX_BYTE}, 8'h88, 16'h2828, T_PTR);
      fast <= 1'b0;
      apb(1'b1, OFF_PTR, 32'h00001234);
      mem_op({16'h0, OP_MEM_LC, BIT_OP_PREFIX_BYTE}, 8'h00, 16'h1234, T_PTR);
   endtask
   task automatic t_idx();
      logic [31:0] insn;
      insn = {OP_MEM_LC, 8'hFE, BIT_OP_PREFIX_BYTE, INDEX_X_PREFIX_BYTE};
      fast <= 1'b1;
      apb(1'b1, OFF_IDX, 32'h00001000);
      apb(1'b1, OFF_BC, 32'h00001111);
      mem_op(insn, 8'h7F, 16'h0FFE, T_IDX);
      fast <= 1'b0;
      apb(1'b1, OFF_INSN, insn);
      apb(1'b1, OFF_BC, 32'h00002222);
      chk("busy_wr", {31'h0, e}, 32'h1);
      wait_idle();
      apb(1'b0, OFF_BC, 32'h0);
      chk("bc", q, 32'h00001111);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_acc();
      t_freeze();
      t_reg();
      t_ptr();
      t_idx();
      report_and_stop();
   end
endmodule
bind rotu_top rotu_sva rotu_sva_inst (.pclk, .presetn, .ce, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_addr, .mem_rd,
   .mem_wr, .mem_wdata, .mem_rdata, .mem_ack, .busy);
`default_nettype wire
